// >>> design/pslc_pkg.sv
// Purpose: Constants for the port error status and link capability registers.
// Assumes: One instance per switch port; port 0 is the upstream port.
// Notes: Offsets are byte addresses of the configuration dwords.
package pslc_pkg;
   // ===========================================================
   // Register offsets
   localparam logic [11:0] PSLC_OFF_DEV_STATUS = 12'h0c8;
   localparam logic [11:0] PSLC_OFF_LINK_CAP = 12'h0cc;
   // ===========================================================
   // Device status field positions
   localparam int PSLC_ST_CORR = 16;
   localparam int PSLC_ST_NFAT = 17;
   localparam int PSLC_ST_FATL = 18;
   localparam int PSLC_ST_UNSR = 19;
   localparam int PSLC_ST_AUXP = 20;
   localparam int PSLC_ST_TPND = 21;
   // ===========================================================
   // Link capability and aux power detected reset values
   localparam logic [3:0] PSLC_SPEED_2G5 = 4'h1;
   localparam logic [3:0] PSLC_SPEED_5G0 = 4'h2;
   localparam logic [5:0] PSLC_WIDTH_UP = 6'h04;
   localparam logic [5:0] PSLC_WIDTH_DN = 6'h02;
   localparam logic [1:0] PSLC_ASPM_RST = 2'h0;
   localparam logic [2:0] PSLC_L0S_RST = 3'h3;
   localparam logic [2:0] PSLC_L1_RST = 3'h0;
   localparam logic PSLC_CLKPM_UP_RST = 1'b1;
   localparam logic PSLC_SDOWN_RST = 1'b0;
   localparam logic PSLC_DLACT_DN_RST = 1'b1;
   localparam logic PSLC_BWN_RST = 1'b0;
   localparam logic PSLC_AUXP_RST = 1'b1;
   // ===========================================================
   // Override load word layout
   localparam int PSLC_OVR_W = 20;
   localparam int PSLC_OVR_ASPM = 0;
   localparam int PSLC_OVR_L0S = 2;
   localparam int PSLC_OVR_L1 = 5;
   localparam int PSLC_OVR_CLKPM = 8;
   localparam int PSLC_OVR_SDOWN = 9;
   localparam int PSLC_OVR_DLACT = 10;
   localparam int PSLC_OVR_BWN = 11;
   localparam int PSLC_OVR_PORT = 12;
endpackage

// >>> design/pslc_regs.sv
// Purpose: Per-port device status and link capability configuration registers.
// Assumes: Config accesses are single-cycle dword reads and writes at a byte offset.
// Notes: Override loads come from the serial management or EEPROM loader.
// Operation
// - Error flags set by hardware, write-one clears
// - Flags log regardless of reporting enables
// - Aux power detected bit, reset one
// - Transactions pending always reads zero
// - Max link speed reads 5.0 Gb/s
// - Max width x4 upstream, x2 downstream
// - ASPM support field resets to zero
// - L0s exit latency resets to 011b
// - L1 exit latency resets to 000b
// - Clock PM one upstream, zero downstream
// - DL active reporting zero upstream, one downstream
// - Bandwidth notify capability resets to zero
// - Port number in top byte
// - Capability defaults overridable by loader, except clock PM downstream and DL active upstream; speed and width stay fixed
module pslc_regs #(
   parameter logic [7:0] PORT_NUM = 8'h00
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Configuration access
   input wire logic cfg_rd,
   input wire logic cfg_wr,
   input wire logic [11:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   input wire logic [3:0] cfg_be,
   output logic [31:0] cfg_rdata,
   output logic cfg_hit,
   // Error events and status inputs
   input wire logic err_corr,
   input wire logic err_nonfatal,
   input wire logic err_fatal,
   input wire logic err_unsup,
   input wire logic aux_pwr_det,
   // Default override load
   input wire logic ovr_load,
   input wire logic [pslc_pkg::PSLC_OVR_W-1:0] ovr_data
);
   import pslc_pkg::*;

   localparam logic IS_UP = (PORT_NUM == 8'h00);

   // ===========================================================
   // Address decode
   function automatic logic is_status(input logic [11:0] addr);
      return addr == PSLC_OFF_DEV_STATUS;
   endfunction

   function automatic logic is_linkcap(input logic [11:0] addr);
      return addr == PSLC_OFF_LINK_CAP;
   endfunction

   // ===========================================================
   // Error flags
   logic [3:0] err_q, err_d;
   logic aux_q, aux_d;
   logic [3:0] clr;
   logic [3:0] ev;

   always_comb begin
      ev = {err_unsup, err_fatal, err_nonfatal, err_corr};
      clr = 4'h0;
      if (cfg_wr && is_status(cfg_addr) && cfg_be[2]) begin
         clr = cfg_wdata[PSLC_ST_UNSR:PSLC_ST_CORR];
      end
      err_d = (err_q & ~clr) | ev;
      aux_d = aux_pwr_det;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         err_q <= 4'h0;
         aux_q <= PSLC_AUXP_RST;
      end else if (clk_en) begin
         err_q <= err_d;
         aux_q <= aux_d;
      end
   end

   // ===========================================================
   // Loadable capability defaults
   logic [1:0] aspm_q, aspm_d;
   logic [2:0] l0s_q, l0s_d;
   logic [2:0] l1_q, l1_d;
   logic clkpm_q, clkpm_d;
   logic sdown_q, sdown_d;
   logic dlact_q, dlact_d;
   logic bwn_q, bwn_d;
   logic [7:0] port_q, port_d;

   always_comb begin
      aspm_d = aspm_q;
      l0s_d = l0s_q;
      l1_d = l1_q;
      clkpm_d = clkpm_q;
      sdown_d = sdown_q;
      dlact_d = dlact_q;
      bwn_d = bwn_q;
      port_d = port_q;
      if (ovr_load) begin
         aspm_d = ovr_data[PSLC_OVR_ASPM+:2];
         l0s_d = ovr_data[PSLC_OVR_L0S+:3];
         l1_d = ovr_data[PSLC_OVR_L1+:3];
         clkpm_d = IS_UP ? ovr_data[PSLC_OVR_CLKPM] : 1'b0;
         sdown_d = ovr_data[PSLC_OVR_SDOWN];
         dlact_d = IS_UP ? 1'b0 : ovr_data[PSLC_OVR_DLACT];
         bwn_d = ovr_data[PSLC_OVR_BWN];
         port_d = ovr_data[PSLC_OVR_PORT+:8];
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         aspm_q <= PSLC_ASPM_RST;
         l0s_q <= PSLC_L0S_RST;
         l1_q <= PSLC_L1_RST;
         clkpm_q <= IS_UP ? PSLC_CLKPM_UP_RST : 1'b0;
         sdown_q <= PSLC_SDOWN_RST;
         dlact_q <= IS_UP ? 1'b0 : PSLC_DLACT_DN_RST;
         bwn_q <= PSLC_BWN_RST;
         port_q <= PORT_NUM;
      end else if (clk_en) begin
         aspm_q <= aspm_d;
         l0s_q <= l0s_d;
         l1_q <= l1_d;
         clkpm_q <= clkpm_d;
         sdown_q <= sdown_d;
         dlact_q <= dlact_d;
         bwn_q <= bwn_d;
         port_q <= port_d;
      end
   end

   // ===========================================================
   // Read path
   logic [31:0] st_word, cap_word;
   logic [31:0] rdata_q, rdata_d;
   logic hit;

   always_comb begin
      st_word = 32'h0;
      st_word[PSLC_ST_UNSR:PSLC_ST_CORR] = err_q;
      st_word[PSLC_ST_AUXP] = aux_q;
      st_word[PSLC_ST_TPND] = 1'b0;
      cap_word = {port_q, 2'h0, bwn_q, dlact_q, sdown_q, clkpm_q, l1_q, l0s_q, aspm_q,
                  IS_UP ? PSLC_WIDTH_UP : PSLC_WIDTH_DN, PSLC_SPEED_5G0};
      hit = is_status(cfg_addr) || is_linkcap(cfg_addr);
      rdata_d = rdata_q;
      if (cfg_rd) begin
         if (is_status(cfg_addr)) begin
            rdata_d = st_word;
         end else if (is_linkcap(cfg_addr)) begin
            rdata_d = cap_word;
         end else begin
            rdata_d = 32'h0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rdata_q <= 32'h0;
      end else if (clk_en) begin
         rdata_q <= rdata_d;
      end
   end

   assign cfg_rdata = rdata_q;
   assign cfg_hit = hit;

   // ===========================================================
   // Checks
   AST_ERR_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && err_fatal |=> err_q[2])
      else $error("fatal flag not set");
   AST_ERR_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_wr && cfg_addr == PSLC_OFF_DEV_STATUS && cfg_be[2] && cfg_wdata[16]
      && !err_corr |=> !err_q[0])
      else $error("correctable flag not cleared");
   AST_ERR_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && !cfg_wr && err_q[3] |=> err_q[3])
      else $error("unsupported flag lost");
   AST_TPND: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(cfg_rd) && $past(cfg_addr) == PSLC_OFF_DEV_STATUS && $past(clk_en)
      |-> cfg_rdata[21] == 1'b0 && cfg_rdata[31:22] == 10'h0)
      else $error("pending or reserved bit set");
   AST_SPEED: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_rd && cfg_addr == PSLC_OFF_LINK_CAP |=> cfg_rdata[3:0] == 4'h2)
      else $error("max speed wrong");
   AST_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_rd && cfg_addr == PSLC_OFF_LINK_CAP
      |=> cfg_rdata[9:4] == (IS_UP ? 6'h04 : 6'h02))
      else $error("max width wrong");
   AST_CLKPM: assert property (@(posedge core_clk) disable iff (!rst_n)
      !IS_UP |-> !clkpm_q)
      else $error("clock pm set downstream");
   AST_DLACT: assert property (@(posedge core_clk) disable iff (!rst_n)
      IS_UP |-> !dlact_q)
      else $error("dl active set upstream");
   AST_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && ovr_load |=> port_q == $past(ovr_data[19:12]) && l0s_q == $past(ovr_data[4:2]))
      else $error("override not loaded");
   AST_RSVD: assert property (@(posedge core_clk) disable iff (!rst_n)
      $past(cfg_rd) && $past(clk_en) && $past(cfg_addr) == PSLC_OFF_LINK_CAP
      |-> cfg_rdata[23:22] == 2'h0)
      else $error("reserved capability bits set");

   AST_ERR_CORR_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && err_corr
      |=> err_q[0])
      else $error("correctable flag not set");

   AST_ERR_NFAT_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && err_nonfatal
      |=> err_q[1])
      else $error("non-fatal flag not set");

   AST_ERR_UNSR_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && err_unsup
      |=> err_q[3])
      else $error("unsupported flag not set");

   AST_ERR_NFAT_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_wr && is_status(cfg_addr) && cfg_be[2] && cfg_wdata[PSLC_ST_NFAT]
      && !err_nonfatal
      |=> !err_q[1])
      else $error("non-fatal flag not cleared");

   AST_ERR_FATL_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_wr && is_status(cfg_addr) && cfg_be[2] && cfg_wdata[PSLC_ST_FATL]
      && !err_fatal
      |=> !err_q[2])
      else $error("fatal flag not cleared");

   AST_ERR_UNSR_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_wr && is_status(cfg_addr) && cfg_be[2] && cfg_wdata[PSLC_ST_UNSR]
      && !err_unsup
      |=> !err_q[3])
      else $error("unsupported flag not cleared");

   AST_ERR_NOSET: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && !err_corr && !err_q[0]
      |=> !err_q[0])
      else $error("correctable flag set with no event");

   AST_ERR_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_n)
      !clk_en
      |=> $stable(err_q))
      else $error("error flags changed while frozen");

   AST_RST_ERR: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n)
      |-> err_q == 4'h0)
      else $error("error flags not zero after reset");

   AST_RST_AUX: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n)
      |-> aux_q == PSLC_AUXP_RST)
      else $error("aux power bit not one after reset");

   AST_RST_ASPM: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n)
      |-> aspm_q == PSLC_ASPM_RST)
      else $error("aspm support not at default after reset");

   AST_RST_L0S: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n)
      |-> l0s_q == PSLC_L0S_RST)
      else $error("l0s exit latency not at default after reset");

   AST_RST_L1: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n)
      |-> l1_q == PSLC_L1_RST)
      else $error("l1 exit latency not at default after reset");

   AST_RST_BWN: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n)
      |-> bwn_q == PSLC_BWN_RST)
      else $error("bandwidth notify bit not zero after reset");

   AST_RST_PORT: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(rst_n)
      |-> port_q == PORT_NUM)
      else $error("port number not at default after reset");

   AST_AUX_RD: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_rd && is_status(cfg_addr)
      |=> cfg_rdata[PSLC_ST_AUXP] == $past(aux_q))
      else $error("aux power bit read wrong");

   AST_FLAGS_RD: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_rd && is_status(cfg_addr)
      |=> cfg_rdata[PSLC_ST_UNSR:PSLC_ST_CORR] == $past(err_q))
      else $error("error flags read wrong");

   AST_CLKPM_RD: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_rd && is_linkcap(cfg_addr) && !IS_UP
      |=> !cfg_rdata[18])
      else $error("clock pm read set downstream");

   AST_DLACT_RD: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_rd && is_linkcap(cfg_addr) && IS_UP
      |=> !cfg_rdata[20])
      else $error("dl active read set upstream");

   AST_CAP_RO: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_wr && !ovr_load
      |=> $stable(port_q) && $stable(l0s_q) && $stable(aspm_q))
      else $error("capability changed by a write");

   AST_UNMAPPED: assert property (@(posedge core_clk) disable iff (!rst_n)
      clk_en && cfg_rd && !cfg_hit
      |=> cfg_rdata == 32'h0)
      else $error("unmapped read not zero");
endmodule

// >>> dv/test_pslc_regs.sv
// Purpose: Self-checking bench for the port status and link capability registers.
// Assumes: Two instances share every input; one is the upstream port, one a downstream port.
// Notes: Inputs change 1 ns after the rising edge; read data is checked after its edge.
module test_pslc_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import pslc_pkg::*;
   // ==========================================================
   // Signals
   logic core_clk, rst_n, clk_en, cfg_rd, cfg_wr, aux_pwr_det, ovr_load;
   logic err_corr, err_nonfatal, err_fatal, err_unsup;
   logic [11:0] cfg_addr;
   logic [31:0] cfg_wdata, rdata_up, rdata_dn;
   logic [3:0] cfg_be;
   logic [PSLC_OVR_W-1:0] ovr_data;
   logic hit_up, hit_dn;
   int err_total = 0;
   int cmp_count = 0;
   // ==========================================================
   // Devices
   pslc_regs #(.PORT_NUM(8'h00)) i_pslc_regs (.core_clk(core_clk), .rst_n(rst_n),
      .clk_en(clk_en), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(rdata_up), .cfg_hit(hit_up),
      .err_corr(err_corr), .err_nonfatal(err_nonfatal), .err_fatal(err_fatal),
      .err_unsup(err_unsup), .aux_pwr_det(aux_pwr_det), .ovr_load(ovr_load),
      .ovr_data(ovr_data));
   pslc_regs #(.PORT_NUM(8'h02)) i_pslc_regs_dn (.core_clk(core_clk), .rst_n(rst_n),
      .clk_en(clk_en), .cfg_rd(cfg_rd), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr),
      .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(rdata_dn), .cfg_hit(hit_dn),
      .err_corr(err_corr), .err_nonfatal(err_nonfatal), .err_fatal(err_fatal),
      .err_unsup(err_unsup), .aux_pwr_det(aux_pwr_det), .ovr_load(ovr_load),
      .ovr_data(ovr_data));
   // ==========================================================
   // Helpers
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
         err_total++;
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e_up, input logic [31:0] e_dn);
      cfg_addr = a;
      cfg_rd = 1'b1;
      #1;
      chk({31'h0, hit_up & hit_dn}, {31'h0, a == 12'h0c8 || a == 12'h0cc}, "hit");
      @(posedge core_clk);
      #1;
      cfg_rd = 1'b0;
      chk(rdata_up, e_up, "upstream read");
      chk(rdata_dn, e_dn, "downstream read");
      @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_be = be;
      cfg_wr = 1'b1;
      @(posedge core_clk);
      #1;
      cfg_wr = 1'b0;
   endtask
   task automatic err_pulse(input logic [3:0] e);
      {err_unsup, err_fatal, err_nonfatal, err_corr} = e;
      @(posedge core_clk);
      #1;
      {err_unsup, err_fatal, err_nonfatal, err_corr} = 4'h0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic test_reset();
      rd(12'h0cc, 32'h00043042, 32'h02103022);
      rd(12'h0c8, 32'h00100000, 32'h00100000);
      rd(12'h0d4, 32'h00000000, 32'h00000000);
      $display("test_reset done");
   endtask
   task automatic test_errors();
      err_pulse(4'h1);
      rd(12'h0c8, 32'h00110000, 32'h00110000);
      err_pulse(4'he);
      rd(12'h0c8, 32'h001f0000, 32'h001f0000);
      wr(12'h0c8, 32'h00050000, 4'hb);
      rd(12'h0c8, 32'h001f0000, 32'h001f0000);
      wr(12'h0c8, 32'hffc50000, 4'hf);
      rd(12'h0c8, 32'h001a0000, 32'h001a0000);
      err_corr = 1'b1;
      wr(12'h0c8, 32'h00010000, 4'hf);
      err_corr = 1'b0;
      rd(12'h0c8, 32'h001b0000, 32'h001b0000);
      wr(12'h0c8, 32'h000f0000, 4'hf);
      rd(12'h0c8, 32'h00100000, 32'h00100000);
      aux_pwr_det = 1'b0;
      @(posedge core_clk);
      #1;
      rd(12'h0c8, 32'h00000000, 32'h00000000);
      aux_pwr_det = 1'b1;
      $display("test_errors done");
   endtask
   task automatic test_override();
      wr(12'h0cc, 32'hffffffff, 4'hf);
      rd(12'h0cc, 32'h00043042, 32'h02103022);
      ovr_data = {8'h5a, 1'b1, 1'b1, 1'b1, 1'b1, 3'h6, 3'h5, 2'h3};
      ovr_load = 1'b1;
      @(posedge core_clk);
      #1;
      ovr_load = 1'b0;
      rd(12'h0cc, 32'h5a2f5c42, 32'h5a3b5c22);
      $display("test_override done");
   endtask
   task automatic test_freeze_reset();
      clk_en = 1'b0;
      err_pulse(4'h4);
      rd(12'h0c8, 32'h5a2f5c42, 32'h5a3b5c22);
      clk_en = 1'b1;
      rd(12'h0c8, 32'h00100000, 32'h00100000);
      rst_n = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      chk(rdata_up, 32'h00000000, "upstream read after reset");
      chk(rdata_dn, 32'h00000000, "downstream read after reset");
      rd(12'h0cc, 32'h00043042, 32'h02103022);
      $display("test_freeze_reset done");
   endtask
   // ==========================================================
   // Clock, sequence and verdict
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial begin
      {rst_n, cfg_rd, cfg_wr, ovr_load, err_corr, err_nonfatal, err_fatal, err_unsup} = '0;
      {clk_en, aux_pwr_det} = 2'b11;
      {cfg_addr, cfg_wdata, cfg_be, ovr_data} = '0;
      repeat (3) @(posedge core_clk);
      #1;
      rst_n = 1'b1;
      test_reset();
      test_errors();
      test_override();
      test_freeze_reset();
      final_report();
   end
endmodule
